// >>> src/lsx_pkg.sv
// Package of opcodes, limits and encodings for the load/store issue controller
package lsx_pkg;

  // --------------------------------------------------------------------
  // Operation codes sent to the load/store unit
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    LSX_OP_ADDR_GEN       = 4'h0,
    LSX_OP_LOAD_WORD      = 4'h1,
    LSX_OP_LOAD_BYTE_U    = 4'h2,
    LSX_OP_LOAD_HALF_U    = 4'h3,
    LSX_OP_LOAD_BYTE_S    = 4'h4,
    LSX_OP_LOAD_HALF_S    = 4'h5,
    LSX_OP_STORE_WORD     = 4'h6,
    LSX_OP_STORE_BYTE     = 4'h7,
    LSX_OP_STORE_HALF     = 4'h8,
    LSX_OP_LOAD_LITERAL   = 4'h9,
    LSX_OP_LOAD_MULTIPLE  = 4'ha,
    LSX_OP_STORE_MULTIPLE = 4'hb,
    LSX_OP_PUSH           = 4'hc,
    LSX_OP_POP            = 4'hd
  } lsx_op_e;

  // --------------------------------------------------------------------
  // Refusal reasons
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    LSX_ERR_NONE      = 3'h0,
    LSX_ERR_RANGE     = 3'h1,
    LSX_ERR_ALIGN     = 3'h2,
    LSX_ERR_LIST      = 3'h3,
    LSX_ERR_WRITEBACK = 3'h4,
    LSX_ERR_BASE_POS  = 3'h5,
    LSX_ERR_INTERWORK = 3'h6
  } lsx_err_e;

  // --------------------------------------------------------------------
  // Offset limits and address constants
  // --------------------------------------------------------------------
  localparam logic [9:0] LSX_PC_REL_MAX = 10'h3fc;    // 1020 bytes
  localparam logic [9:0] LSX_SP_WORD_MAX = 10'h3fc;   // 1020 bytes
  localparam logic [9:0] LSX_LOW_WORD_MAX = 10'h07c;  // 124 bytes
  localparam logic [9:0] LSX_HALF_MAX = 10'h03e;      // 62 bytes
  localparam logic [9:0] LSX_BYTE_MAX = 10'h01f;      // 31 bytes
  localparam logic [31:0] LSX_PC_AHEAD = 32'h0000_0004;
  localparam int LSX_LIST_W = 9;                       // R0-R7 plus LR/PC slot
  localparam int LSX_EXTRA_BIT = 8;                    // LR for push, PC for pop

endpackage

// >>> src/lsx_legal_chk.sv
// Combinational legality check of one memory access request
`timescale 1ns/100ps
module lsx_legal_chk
  import lsx_pkg::*;
(
  input wire lsx_op_e i_op,
  input wire logic i_reg_offset,
  input wire logic i_use_sp,
  input wire logic [9:0] i_imm,
  input wire logic [31:0] i_base_val,
  input wire logic [31:0] i_off_val,
  input wire logic [31:0] i_pc_val,
  input wire logic [2:0] i_base_reg,
  input wire logic [8:0] i_reglist,
  input wire logic i_writeback,
  input wire logic i_interwork,
  output lsx_err_e o_err
);

  logic [31:0] addr;
  logic [7:0] low_mask;
  logic base_in_list;
  logic base_is_lowest;

  // --------------------------------------------------------------------
  // Effective address, as the unit will form it
  // --------------------------------------------------------------------
  always_comb begin
    addr = i_base_val + {22'h0, i_imm};  // Omitted immediate arrives as zero
    if (i_reg_offset) begin
      addr = i_base_val + i_off_val;
    end
    if (i_op == LSX_OP_ADDR_GEN || i_op == LSX_OP_LOAD_LITERAL) begin
      addr = i_pc_val + LSX_PC_AHEAD + {22'h0, i_imm};
    end
  end

  // Registers below the base in the list; empty means base is first
  assign low_mask = (8'h01 << i_base_reg) - 8'h01;
  assign base_in_list = i_reglist[i_base_reg];
  assign base_is_lowest = (i_reglist[7:0] & low_mask) == 8'h00;

  // --------------------------------------------------------------------
  // Checks, first failing one reported
  // --------------------------------------------------------------------
  always_comb begin
    o_err = LSX_ERR_NONE;
    unique case (i_op)
      LSX_OP_ADDR_GEN, LSX_OP_LOAD_LITERAL: begin
        if (i_imm > LSX_PC_REL_MAX) begin
          o_err = LSX_ERR_RANGE;
        end else if (i_imm[1:0] != 2'b00) begin
          o_err = LSX_ERR_ALIGN;
        end else if (i_op == LSX_OP_ADDR_GEN && i_interwork && !addr[0]) begin
          o_err = LSX_ERR_INTERWORK;
        end
      end
      LSX_OP_LOAD_WORD, LSX_OP_STORE_WORD: begin
        if (!i_reg_offset && (i_imm[1:0] != 2'b00 ||
            i_imm > (i_use_sp ? LSX_SP_WORD_MAX : LSX_LOW_WORD_MAX))) begin
          o_err = LSX_ERR_RANGE;
        end else if (addr[1:0] != 2'b00) begin
          o_err = LSX_ERR_ALIGN;
        end
      end
      LSX_OP_LOAD_HALF_U, LSX_OP_LOAD_HALF_S, LSX_OP_STORE_HALF: begin
        if (!i_reg_offset && (i_imm[0] || i_imm > LSX_HALF_MAX || i_use_sp)) begin
          o_err = LSX_ERR_RANGE;
        end else if (addr[0]) begin
          o_err = LSX_ERR_ALIGN;
        end
      end
      LSX_OP_LOAD_BYTE_U, LSX_OP_LOAD_BYTE_S, LSX_OP_STORE_BYTE: begin
        // Byte accesses never misalign
        if (!i_reg_offset && (i_imm > LSX_BYTE_MAX || i_use_sp)) begin
          o_err = LSX_ERR_RANGE;
        end
      end
      LSX_OP_LOAD_MULTIPLE, LSX_OP_STORE_MULTIPLE: begin
        if (i_reglist[7:0] == 8'h00 || i_reglist[LSX_EXTRA_BIT]) begin
          o_err = LSX_ERR_LIST;
        end else if (i_base_val[1:0] != 2'b00) begin
          o_err = LSX_ERR_ALIGN;
        end else if (i_writeback == (i_op == LSX_OP_LOAD_MULTIPLE && base_in_list)) begin
          o_err = LSX_ERR_WRITEBACK;
        end else if (i_op == LSX_OP_STORE_MULTIPLE && base_in_list && !base_is_lowest) begin
          o_err = LSX_ERR_BASE_POS;
        end
      end
      LSX_OP_PUSH, LSX_OP_POP: begin
        if (i_reglist == 9'h000) begin
          o_err = LSX_ERR_LIST;
        end else if (i_base_val[1:0] != 2'b00) begin
          o_err = LSX_ERR_ALIGN;
        end
      end
      default: begin
        o_err = LSX_ERR_RANGE;  // Unused opcode codes
      end
    endcase
  end

endmodule

// >>> src/lsx_issue_ctrl.sv
// Issue controller that feeds checked memory access requests to the load/store unit
//
// Overview of operation
// - Address generation targets word-aligned location within 1020 bytes.
// - Word offsets multiple of four, up to 1020 with stack, 124 otherwise.
// - Halfword offsets even up to 62; byte offsets 0 to 31.
// - Single access address must be multiple of transfer size.
// - Literal load reads word-aligned word within 1020 bytes of program counter.
// - Writeback always, except load multiple containing base, where it is forbidden.
// - Store multiple containing base must list base first.
// - Pop into program counter branches; loaded bit 0 must be one.
// - Push and pop lists non-empty, low registers plus link or program counter.
// - Address meant as interworking branch target must have bit 0 set.
`timescale 1ns/100ps
module lsx_issue_ctrl
  import lsx_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // User request side
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire lsx_op_e i_req_op,
  input wire logic i_req_reg_offset,
  input wire logic i_req_use_sp,
  input wire logic [2:0] i_req_transfer_reg,
  input wire logic [2:0] i_req_base_reg,
  input wire logic [2:0] i_req_offset_reg,
  input wire logic [9:0] i_req_imm,
  input wire logic [8:0] i_req_reglist,
  input wire logic i_req_writeback,
  input wire logic i_req_interwork,
  input wire logic [31:0] i_req_base_val,
  input wire logic [31:0] i_req_off_val,
  input wire logic [31:0] i_req_pc_val,
  output logic o_rsp_done,
  output logic o_rsp_reject,
  output lsx_err_e o_rsp_err,
  output logic o_rsp_fault,
  output logic o_rsp_branch_bad,
  // Load/store unit side
  output logic o_issue_valid,
  input wire logic i_issue_ready,
  output lsx_op_e o_issue_op,
  output logic o_issue_reg_offset,
  output logic o_issue_use_sp,
  output logic [2:0] o_issue_transfer_reg,
  output logic [2:0] o_issue_base_reg,
  output logic [2:0] o_issue_offset_reg,
  output logic [9:0] o_issue_imm,
  output logic [8:0] o_issue_reglist,
  output logic o_issue_writeback,
  input wire logic i_unit_done,
  input wire logic i_unit_fault,
  input wire logic i_unit_pc_loaded,
  input wire logic [31:0] i_unit_pc_val
);

  typedef enum logic [1:0] {
    LSX_ST_IDLE  = 2'b00,
    LSX_ST_CHECK = 2'b01,
    LSX_ST_ISSUE = 2'b10,
    LSX_ST_WAIT  = 2'b11
  } lsx_state_e;

  lsx_state_e state_reg;
  lsx_err_e chk_err;
  logic [31:0] base_val_reg;
  logic [31:0] off_val_reg;
  logic [31:0] pc_val_reg;
  logic interwork_reg;

  // --------------------------------------------------------------------
  // Legality check on the captured request
  // --------------------------------------------------------------------
  lsx_legal_chk u_chk (
    .i_op(o_issue_op),
    .i_reg_offset(o_issue_reg_offset),
    .i_use_sp(o_issue_use_sp),
    .i_imm(o_issue_imm),
    .i_base_val(base_val_reg),
    .i_off_val(off_val_reg),
    .i_pc_val(pc_val_reg),
    .i_base_reg(o_issue_base_reg),
    .i_reglist(o_issue_reglist),
    .i_writeback(o_issue_writeback),
    .i_interwork(interwork_reg),
    .o_err(chk_err)
  );

  // Handshakes straight from state
  assign o_req_ready = (state_reg == LSX_ST_IDLE);
  assign o_issue_valid = (state_reg == LSX_ST_ISSUE);

  // --------------------------------------------------------------------
  // Condition flags
  // --------------------------------------------------------------------
  // No flag port at all, so no access can disturb the flags

  // --------------------------------------------------------------------
  // Sequencer: capture, check, issue, wait for completion
  // --------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg <= LSX_ST_IDLE;
    end else begin
      unique case (state_reg)
        LSX_ST_IDLE: begin
          if (i_req_valid) begin
            state_reg <= LSX_ST_CHECK;
          end
        end
        LSX_ST_CHECK: begin
          // Illegal requests never reach the unit
          // Misaligned accesses are stopped here, except literal loads, whose program counter alignment is never checked
          state_reg <= (chk_err == LSX_ERR_NONE) ? LSX_ST_ISSUE : LSX_ST_IDLE;
        end
        LSX_ST_ISSUE: begin
          // One request outstanding; fields held until the unit accepts
          if (i_issue_ready) begin
            state_reg <= LSX_ST_WAIT;
          end
        end
        LSX_ST_WAIT: begin
          // Multiple transfers finish once after all word accesses
          if (i_unit_done) begin
            state_reg <= LSX_ST_IDLE;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Request capture; held stable while the unit owns the request
  // --------------------------------------------------------------------
  // Opcode carries size and extension to the unit
  // List and writeback pass whole; unit steps words upward
  // Push and pop direction follows the opcode alone
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_issue_op <= LSX_OP_ADDR_GEN;
      o_issue_reg_offset <= 1'b0;
      o_issue_use_sp <= 1'b0;
      o_issue_transfer_reg <= 3'h0;
      o_issue_base_reg <= 3'h0;
      o_issue_offset_reg <= 3'h0;
      o_issue_imm <= 10'h000;
      o_issue_reglist <= 9'h000;
      o_issue_writeback <= 1'b0;
      interwork_reg <= 1'b0;
      base_val_reg <= 32'h0000_0000;
      off_val_reg <= 32'h0000_0000;
      pc_val_reg <= 32'h0000_0000;
    end else if (o_req_ready && i_req_valid) begin
      o_issue_op <= i_req_op;
      o_issue_reg_offset <= i_req_reg_offset;
      o_issue_use_sp <= i_req_use_sp;
      o_issue_transfer_reg <= i_req_transfer_reg;
      o_issue_base_reg <= i_req_base_reg;
      o_issue_offset_reg <= i_req_offset_reg;
      o_issue_imm <= i_req_imm;
      o_issue_reglist <= i_req_reglist;
      o_issue_writeback <= i_req_writeback;
      interwork_reg <= i_req_interwork;
      base_val_reg <= i_req_base_val;
      off_val_reg <= i_req_off_val;
      pc_val_reg <= i_req_pc_val;
    end
  end

  // --------------------------------------------------------------------
  // Reject pulse and its reason
  // --------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rsp_reject <= 1'b0;
      o_rsp_err <= LSX_ERR_NONE;
    end else begin
      o_rsp_reject <= (state_reg == LSX_ST_CHECK) && (chk_err != LSX_ERR_NONE);
      if (state_reg == LSX_ST_CHECK) begin
        o_rsp_err <= chk_err;  // Reason kept until next check
      end
    end
  end

  // --------------------------------------------------------------------
  // Completion pulse, fault and bad branch state
  // --------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rsp_done <= 1'b0;
      o_rsp_fault <= 1'b0;
      o_rsp_branch_bad <= 1'b0;
    end else begin
      o_rsp_done <= (state_reg == LSX_ST_WAIT) && i_unit_done;
      if ((state_reg == LSX_ST_WAIT) && i_unit_done) begin
        // Fault reported by the unit with its completion
        o_rsp_fault <= i_unit_fault;
        // Popped program counter must carry bit 0 set
        o_rsp_branch_bad <= (o_issue_op == LSX_OP_POP) && o_issue_reglist[LSX_EXTRA_BIT]
                            && i_unit_pc_loaded && !i_unit_pc_val[0];
      end
    end
  end

endmodule

// >>> bench/lsx_issue_ctrl_assertions.sv
// Concurrent checks on the issue controller ports
`timescale 1ns/100ps
module lsx_issue_ctrl_assertions
  import lsx_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic o_rsp_done,
  input wire logic o_rsp_reject,
  input wire lsx_err_e o_rsp_err,
  input wire logic o_rsp_fault,
  input wire logic o_rsp_branch_bad,
  input wire logic o_issue_valid,
  input wire logic i_issue_ready,
  input wire lsx_op_e o_issue_op,
  input wire logic o_issue_reg_offset,
  input wire logic o_issue_use_sp,
  input wire logic [2:0] o_issue_base_reg,
  input wire logic [9:0] o_issue_imm,
  input wire logic [8:0] o_issue_reglist,
  input wire logic o_issue_writeback,
  input wire logic i_unit_done,
  input wire logic i_unit_fault,
  input wire logic i_unit_pc_loaded,
  input wire logic [31:0] i_unit_pc_val
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Single bit kept apart so $past sees a plain signal
  logic pc_bit0;
  assign pc_bit0 = i_unit_pc_val[0];
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  property p_reject;
    o_rsp_reject |-> o_rsp_err != LSX_ERR_NONE && !o_issue_valid;
  endproperty
  a_reject: assert property (p_reject) else $error("refused request issued or without code");
  property p_take;
    o_req_ready && i_req_valid |=> !o_req_ready ##1 (o_issue_valid || o_rsp_reject);
  endproperty
  a_take: assert property (p_take) else $error("request not answered two cycles after take");
  property p_hold;
    o_issue_valid && !i_issue_ready |=> o_issue_valid && $stable(o_issue_imm) && $stable(o_issue_reglist);
  endproperty
  a_hold: assert property (p_hold) else $error("issue dropped or changed before ready");
  property p_done;
    i_unit_done && !o_req_ready |=> o_rsp_done && o_rsp_fault == $past(i_unit_fault)
      && o_rsp_branch_bad == ($past(i_unit_pc_loaded) && !$past(pc_bit0));
  endproperty
  a_done: assert property (p_done) else $error("completion report wrong");
  property p_list;
    o_issue_valid && o_issue_op inside {LSX_OP_LOAD_MULTIPLE, LSX_OP_STORE_MULTIPLE}
      |-> o_issue_reglist[7:0] != 8'h00 && !o_issue_reglist[8];
  endproperty
  a_list: assert property (p_list) else $error("bad list issued for multiple");
  property p_wb;
    o_issue_valid && o_issue_op inside {LSX_OP_LOAD_MULTIPLE, LSX_OP_STORE_MULTIPLE} |-> o_issue_writeback
      == !(o_issue_op == LSX_OP_LOAD_MULTIPLE && o_issue_reglist[o_issue_base_reg]);
  endproperty
  a_wb: assert property (p_wb) else $error("writeback choice issued wrongly");
  property p_word;
    o_issue_valid && !o_issue_reg_offset && o_issue_op inside {LSX_OP_LOAD_WORD, LSX_OP_STORE_WORD}
      |-> o_issue_imm[1:0] == 2'h0 && o_issue_imm <= (o_issue_use_sp ? 10'h3fc : 10'h07c);
  endproperty
  a_word: assert property (p_word) else $error("word offset out of range issued");
  property p_small;
    o_issue_valid && !o_issue_reg_offset && o_issue_op inside {LSX_OP_LOAD_HALF_U, LSX_OP_LOAD_HALF_S,
      LSX_OP_STORE_HALF} |-> !o_issue_use_sp && !o_issue_imm[0] && o_issue_imm <= 10'h03e;
  endproperty
  a_small: assert property (p_small) else $error("halfword offset out of range issued");
endmodule

// >>> bench/lsx_unit_model.sv
// Behavioural load/store unit answering the issue controller
`timescale 1ns/100ps
module lsx_unit_model
  import lsx_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_issue_valid,
  input wire lsx_op_e i_issue_op,
  input wire logic [8:0] i_issue_reglist,
  input wire logic [1:0] i_stall,
  input wire logic i_fault_cmd,
  input wire logic [31:0] i_pop_pc,
  output logic o_issue_ready,
  output logic o_unit_done,
  output logic o_unit_fault,
  output logic o_unit_pc_loaded,
  output logic [31:0] o_unit_pc_val
);
  logic [4:0] cnt_reg;
  logic busy_reg;
  logic [4:0] words;
  // One word access per listed register for multiples
  assign words = i_issue_op inside {LSX_OP_LOAD_MULTIPLE, LSX_OP_STORE_MULTIPLE, LSX_OP_PUSH, LSX_OP_POP}
    ? 5'($countones(i_issue_reglist)) : 5'h01;
  // Accept after a stall, then finish after the word count plus the stall again
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= 5'h00;
      busy_reg <= 1'b0;
      o_issue_ready <= 1'b0;
      o_unit_done <= 1'b0;
    end else begin
      o_issue_ready <= 1'b0;
      o_unit_done <= 1'b0;
      if (o_issue_ready) begin
        busy_reg <= 1'b1;
        cnt_reg <= words + 5'(i_stall);
      end else if (busy_reg) begin
        if (cnt_reg == 5'h00) begin
          busy_reg <= 1'b0;
          o_unit_done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 5'h01;
        end
      end else if (i_issue_valid) begin
        if (cnt_reg == 5'(i_stall)) begin
          o_issue_ready <= 1'b1;
          cnt_reg <= 5'h00;
        end else begin
          cnt_reg <= cnt_reg + 5'h01;
        end
      end
    end
  end
  // Answer fields valid only with done; fault and PC loaded zero otherwise, PC value inverted
  assign o_unit_fault = o_unit_done & i_fault_cmd;
  assign o_unit_pc_loaded = o_unit_done && i_issue_op == LSX_OP_POP && i_issue_reglist[8];
  assign o_unit_pc_val = o_unit_done ? i_pop_pc : ~i_pop_pc;
endmodule

// >>> bench/test_lsx_issue_ctrl.sv
// Self-checking bench for the issue controller
`timescale 1ns/100ps
module test_lsx_issue_ctrl;
  import lsx_pkg::*;
  logic i_sys_clk = 0, i_rst_n = 0, i_req_valid = 0, i_req_reg_offset = 0, i_req_use_sp = 0;
  logic i_req_writeback = 0, i_req_interwork = 0, i_issue_ready, i_unit_done, i_unit_fault, i_unit_pc_loaded;
  lsx_op_e i_req_op = LSX_OP_ADDR_GEN;
  logic [2:0] i_req_transfer_reg = 0, i_req_base_reg = 0, i_req_offset_reg = 0;
  logic [9:0] i_req_imm = 0;
  logic [8:0] i_req_reglist = 0;
  logic [31:0] i_req_base_val = 0, i_req_off_val = 0, i_req_pc_val = 0, i_unit_pc_val, pop_pc = 0;
  logic [1:0] stall = 0;
  logic fault_cmd = 0;
  logic o_req_ready, o_rsp_done, o_rsp_reject, o_rsp_fault, o_rsp_branch_bad, o_issue_valid;
  logic o_issue_reg_offset, o_issue_use_sp, o_issue_writeback;
  lsx_err_e o_rsp_err;
  lsx_op_e o_issue_op;
  logic [2:0] o_issue_transfer_reg, o_issue_base_reg, o_issue_offset_reg;
  logic [9:0] o_issue_imm;
  logic [8:0] o_issue_reglist;
  int num_errors = 0, checks = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  lsx_issue_ctrl i_lsx_issue_ctrl (.*);
  lsx_unit_model i_lsx_unit_model (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_issue_valid(o_issue_valid),
    .i_issue_op(o_issue_op), .i_issue_reglist(o_issue_reglist), .i_stall(stall), .i_fault_cmd(fault_cmd),
    .i_pop_pc(pop_pc), .o_issue_ready(i_issue_ready), .o_unit_done(i_unit_done), .o_unit_fault(i_unit_fault),
    .o_unit_pc_loaded(i_unit_pc_loaded), .o_unit_pc_val(i_unit_pc_val));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Legality worked out from the request fields
  function automatic bit exp_ok();
    int s;
    logic [31:0] a;
    s = i_req_op inside {LSX_OP_LOAD_WORD, LSX_OP_STORE_WORD} ? 4 :
      i_req_op inside {LSX_OP_LOAD_HALF_U, LSX_OP_LOAD_HALF_S, LSX_OP_STORE_HALF} ? 2 : 1;
    a = i_req_base_val + (i_req_reg_offset ? i_req_off_val : {22'h0, i_req_imm});
    case (i_req_op)
      LSX_OP_ADDR_GEN, LSX_OP_LOAD_LITERAL:
        return i_req_imm <= 1020 && i_req_imm[1:0] == 0 && !(i_req_interwork && !i_req_pc_val[0]);
      LSX_OP_LOAD_MULTIPLE, LSX_OP_STORE_MULTIPLE:
        return i_req_reglist[7:0] != 0 && !i_req_reglist[8] && i_req_base_val[1:0] == 0
          && i_req_writeback == !(i_req_op == LSX_OP_LOAD_MULTIPLE && i_req_reglist[i_req_base_reg])
          && !(i_req_op == LSX_OP_STORE_MULTIPLE && i_req_reglist[i_req_base_reg]
          && (i_req_reglist[7:0] & ((8'h1 << i_req_base_reg) - 8'h1)) != 0);
      LSX_OP_PUSH, LSX_OP_POP:
        return i_req_reglist != 0 && i_req_base_val[1:0] == 0;
      default:
        return i_req_op <= 4'hd && a % s == 0 && (i_req_reg_offset || (!(i_req_use_sp && s != 4)
          && i_req_imm <= (s == 4 ? (i_req_use_sp ? 1020 : 124) : s == 2 ? 62 : 31) && i_req_imm % s == 0));
    endcase
  endfunction
  // Present one request, wait for its answer and judge it
  task automatic go(input lsx_op_e op, input logic ro, sp, input logic [9:0] imm, input logic [8:0] lst,
      input logic wb, input logic [2:0] b, input logic [31:0] bv, input logic iw, input logic [3:0] xe);
    int n;
    bit k;
    @(posedge i_sys_clk);
    {i_req_op, i_req_reg_offset, i_req_use_sp, i_req_imm, i_req_reglist} <= {op, ro, sp, imm, lst};
    {i_req_writeback, i_req_base_reg, i_req_base_val, i_req_interwork} <= {wb, b, bv, iw};
    i_req_off_val <= (32'($urandom_range(0, 63)) << 2) | {31'h0, ~xe[3] & (xe != 4'h2) & bv[0]};
    i_req_pc_val <= 32'($urandom_range(0, 4095)) << 2;
    stall <= 2'($urandom);
    {i_req_transfer_reg, i_req_offset_reg} <= 6'($urandom);
    i_req_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_req_valid <= 1'b0;
    k = exp_ok();
    for (n = 0; n < 200 && o_rsp_done !== 1'b1 && o_rsp_reject !== 1'b1; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    if (n == 200) begin
      num_errors++;
      tally_and_finish();
    end
    chk("reject", !k, o_rsp_reject);
    chk("done", k, o_rsp_done);
    if (xe != 4'hf || k)
      chk("err", k ? 0 : xe, o_rsp_err);
    if (k) begin
      chk("issue", {op, imm, lst, wb}, {o_issue_op, o_issue_imm, o_issue_reglist, o_issue_writeback});
      chk("regs", {i_req_transfer_reg, b, i_req_offset_reg, ro, sp}, {o_issue_transfer_reg, o_issue_base_reg,
        o_issue_offset_reg, o_issue_reg_offset, o_issue_use_sp});
      chk("fault", fault_cmd, o_rsp_fault);
      chk("branch", op == LSX_OP_POP && lst[8] && !pop_pc[0], o_rsp_branch_bad);
    end
  endtask
  task automatic do_reset();
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    #1;
    chk("reset", 2'b10, {o_req_ready, o_issue_valid});
  endtask
  initial begin
    void'($urandom(32'hcc9141aa));
    do_reset();
    go(LSX_OP_LOAD_WORD, 0, 0, 10'd124, 0, 0, 1, 32'h100, 0, 0);
    go(LSX_OP_LOAD_WORD, 0, 0, 10'd128, 0, 0, 1, 32'h100, 0, 1);
    go(LSX_OP_STORE_WORD, 0, 1, 10'd1020, 0, 0, 1, 32'h100, 0, 0);
    go(LSX_OP_LOAD_HALF_S, 0, 0, 10'd62, 0, 0, 2, 32'h200, 0, 0);
    go(LSX_OP_STORE_HALF, 0, 0, 10'd64, 0, 0, 2, 32'h200, 0, 1);
    go(LSX_OP_LOAD_HALF_U, 0, 1, 10'd2, 0, 0, 2, 32'h200, 0, 1);
    go(LSX_OP_LOAD_BYTE_S, 0, 0, 10'd31, 0, 0, 3, 32'h203, 0, 0);
    go(LSX_OP_STORE_BYTE, 0, 0, 10'd32, 0, 0, 3, 32'h203, 0, 1);
    go(LSX_OP_LOAD_HALF_U, 1, 0, 10'd0, 0, 0, 4, 32'h201, 0, 2);
    go(LSX_OP_ADDR_GEN, 0, 0, 10'd1020, 0, 0, 0, 0, 0, 0);
    go(LSX_OP_LOAD_LITERAL, 0, 0, 10'd1023, 0, 0, 0, 0, 0, 1);
    go(LSX_OP_ADDR_GEN, 0, 0, 10'd16, 0, 0, 0, 0, 1, 6);
    go(LSX_OP_LOAD_MULTIPLE, 0, 0, 0, 9'h0ff, 0, 7, 32'h300, 0, 0);
    go(LSX_OP_LOAD_MULTIPLE, 0, 0, 0, 9'h019, 1, 3, 32'h300, 0, 4);
    go(LSX_OP_STORE_MULTIPLE, 0, 0, 0, 9'h070, 1, 5, 32'h300, 0, 5);
    go(LSX_OP_STORE_MULTIPLE, 0, 0, 0, 9'h000, 1, 5, 32'h300, 0, 3);
    go(LSX_OP_LOAD_MULTIPLE, 0, 0, 0, 9'h101, 1, 5, 32'h300, 0, 3);
    go(LSX_OP_STORE_MULTIPLE, 0, 0, 0, 9'h003, 1, 2, 32'h302, 0, 2);
    go(LSX_OP_PUSH, 0, 0, 0, 9'h100, 0, 0, 32'h400, 0, 0);
    go(lsx_op_e'(4'he), 0, 0, 0, 0, 0, 0, 0, 0, 1);
    pop_pc <= 32'h0000_1000;
    fault_cmd <= 1'b1;
    go(LSX_OP_POP, 0, 0, 0, 9'h141, 0, 0, 32'h400, 0, 0);
    fault_cmd <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      automatic logic [31:0] r = $urandom;
      if (i == 150)
        do_reset();
      pop_pc <= $urandom;
      go(lsx_op_e'(r[12:9]), r[1], r[0] & ~r[1], r[3] ? r[22:13] : {5'h0, r[7:5], 2'h0},
        {r[22] & r[3], r[21:14]}, r[23], r[26:24], {30'($urandom_range(0, 1023)), r[31] ? r[28:27] : 2'h0}, 0,
        4'hf);
    end
    tally_and_finish();
  end
endmodule
bind lsx_issue_ctrl lsx_issue_ctrl_assertions i_lsx_issue_ctrl_assertions (.*);
